// ---- ddr3_mpr_bank.sv ----
// DDR3 multi purpose register readout and per-bank row state
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "ddr3_cmd_map.svh"

module ddr3_mpr_bank
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire ddr3_cmd_pkg::cmd_t cmd,
	input wire logic [2:0] cmd_ba,
	input wire logic [15:0] cmd_addr,
	output logic [7:0] dq_out,
	output logic dq_oe,
	output logic array_rd,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import ddr3_cmd_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [1:0] ctrl_ff;
	logic mpr_en_ff;
	logic [1:0] mpr_loc_ff;
	logic otf_ff;
	logic [4:0] lat_ff;
	logic [2:0] row_sel_ff;
	bank_state_t bank_ff [8];
	logic [15:0] row_ff [8];
	logic [3:0] trp_cnt_ff [8];
	logic [31:0] pipe_ff;
	logic [31:0] upper_pipe_ff;
	logic [31:0] chop_pipe_ff;
	rd_state_t rd_state_ff;
	logic [2:0] beat_ff;
	logic [2:0] last_beat_ff;
	logic [7:0] dq_beat;
	logic [7:0] pattern;
	logic aw_held_ff;
	logic w_held_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic wr_go;
	logic chop;
	logic mpr_rd;

	// ----------------------------------------------------------------
	// Mode register 3 / mode register 0 capture
	// ----------------------------------------------------------------
	// MRS: bank 3 is MR3, bank 0 is MR0; software may also set them
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mpr_en_ff <= 1'b0;
			mpr_loc_ff <= 2'h0;
			otf_ff <= 1'b1;
		end
		else if (cmd == cmd_mrs && cmd_ba == 3'h3)
		begin
			mpr_en_ff <= cmd_addr[`MR3_MPR_EN_BIT];
			mpr_loc_ff <= cmd_addr[1:0];
		end
		else if (cmd == cmd_mrs && cmd_ba == 3'h0)
			otf_ff <= (cmd_addr[1:0] == 2'h1);
		else if (wr_go && awaddr_ff == `REG_MODE && wstrb_ff[0])
		begin
			mpr_en_ff <= wdata_ff[`MODE_MPR_EN];
			mpr_loc_ff <= wdata_ff[1:0];
			otf_ff <= wdata_ff[`MODE_OTF];
		end
	end

	// ----------------------------------------------------------------
	// Bank row state
	// ----------------------------------------------------------------
	genvar b;
	generate
		for (b = 0; b < 8; b = b + 1)
		begin : banks
			logic hit_act;
			logic hit_pre;
			assign hit_act = (cmd == cmd_act) && (cmd_ba == 3'(b));
			assign hit_pre = (cmd == cmd_pre) &&
				(cmd_addr[`A_AP] || cmd_ba == 3'(b));
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					bank_ff[b] <= bank_idle;
					row_ff[b] <= 16'h0000;
					trp_cnt_ff[b] <= 4'h0;
				end
				else if (hit_pre)
				begin
					// Any state accepts it; the period restarts here
					bank_ff[b] <= bank_precharging;
					trp_cnt_ff[b] <= 4'(`TRP_CYC);
				end
				else if (hit_act)
				begin
					bank_ff[b] <= bank_open;
					row_ff[b] <= cmd_addr;
				end
				else if (bank_ff[b] == bank_precharging)
				begin
					if (trp_cnt_ff[b] <= 4'h1)
						bank_ff[b] <= bank_idle;
					trp_cnt_ff[b] <= trp_cnt_ff[b] - 4'h1;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read command decode and latency pipe
	// ----------------------------------------------------------------
	// A12 picks the burst length only when on-the-fly chop is on
	assign chop = otf_ff ? !cmd_addr[`A_BC] : 1'b0;
	// Only A2 and A12 matter; bank and other column bits ignored
	assign mpr_rd = (cmd == cmd_rd) && mpr_en_ff;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pipe_ff <= 32'h0;
			chop_pipe_ff <= 32'h0;
			upper_pipe_ff <= 32'h0;
		end
		else
		begin
			pipe_ff <= {pipe_ff[30:0], mpr_rd};
			chop_pipe_ff <= {chop_pipe_ff[30:0], chop};
			// Upper nibble first only for a chopped read with A2 high
			upper_pipe_ff <= {upper_pipe_ff[30:0], chop && cmd_addr[2]};
		end
	end

	// ----------------------------------------------------------------
	// Beat sequencer
	// ----------------------------------------------------------------
	// Reserved locations read as the defined pattern location
	assign pattern = `MPR_PATTERN;

	mpr_beat_gen u_beat
	(
		.pattern(pattern),
		.beat(beat_ff),
		.replicate(ctrl_ff[`CTRL_REPL]),
		.dq(dq_beat)
	);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd_state_ff <= rd_wait;
			beat_ff <= 3'h0;
			last_beat_ff <= 3'h0;
			dq_oe <= 1'b0;
			dq_out <= 8'h00;
		end
		else
		begin
			case (rd_state_ff)
				rd_wait:
				begin
					dq_oe <= 1'b0;
					dq_out <= 8'h00;
					if (pipe_ff[lat_ff])
					begin
						rd_state_ff <= rd_burst;
						beat_ff <= {upper_pipe_ff[lat_ff], 2'h0};
						last_beat_ff <= chop_pipe_ff[lat_ff] ?
							{upper_pipe_ff[lat_ff], `BEAT_CHOP_LAST} : `BEAT_LAST;
					end
				end
				rd_burst:
				begin
					dq_oe <= 1'b1;
					dq_out <= dq_beat;
					beat_ff <= beat_ff + 3'h1;
					if (beat_ff == last_beat_ff)
						rd_state_ff <= rd_wait;
				end
				default:
					rd_state_ff <= rd_wait;
			endcase
		end
	end

	// Non-MPR reads go to the array
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			array_rd <= 1'b0;
		else
			array_rd <= (cmd == cmd_rd) && !mpr_en_ff;
	end

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	assign wr_go = aw_held_ff && w_held_ff && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h0;
			wstrb_ff <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OK;
		end
		else
		begin
			s_axi_awready <= !aw_held_ff && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_held_ff && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (awaddr_ff == `REG_CTRL || awaddr_ff == `REG_MODE ||
					awaddr_ff == `REG_ROW_SEL || awaddr_ff == `REG_LAT)
					s_axi_bresp <= `RESP_OK;
				else
					s_axi_bresp <= `RESP_ERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Software control registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_ff <= `CTRL_RST;
			lat_ff <= `LAT_RST;
			row_sel_ff <= 3'h0;
		end
		else if (wr_go && wstrb_ff[0])
		begin
			if (awaddr_ff == `REG_CTRL)
				ctrl_ff <= wdata_ff[1:0];
			else if (awaddr_ff == `REG_ROW_SEL)
				row_sel_ff <= wdata_ff[2:0];
			else if (awaddr_ff == `REG_LAT)
				lat_ff <= wdata_ff[4:0];
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `RESP_OK;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RESP_OK;
				if (s_axi_araddr == `REG_CTRL)
					s_axi_rdata <= {30'h0, ctrl_ff};
				else if (s_axi_araddr == `REG_MODE)
					s_axi_rdata <= {28'h0, otf_ff, mpr_en_ff, mpr_loc_ff};
				else if (s_axi_araddr == `REG_BANK_OPEN)
					s_axi_rdata <= {24'h0,
						bank_ff[7] == bank_open, bank_ff[6] == bank_open,
						bank_ff[5] == bank_open, bank_ff[4] == bank_open,
						bank_ff[3] == bank_open, bank_ff[2] == bank_open,
						bank_ff[1] == bank_open, bank_ff[0] == bank_open};
				else if (s_axi_araddr == `REG_BANK_PRE)
					s_axi_rdata <= {24'h0,
						bank_ff[7] == bank_precharging, bank_ff[6] == bank_precharging,
						bank_ff[5] == bank_precharging, bank_ff[4] == bank_precharging,
						bank_ff[3] == bank_precharging, bank_ff[2] == bank_precharging,
						bank_ff[1] == bank_precharging, bank_ff[0] == bank_precharging};
				else if (s_axi_araddr == `REG_ROW_SEL)
					s_axi_rdata <= {29'h0, row_sel_ff};
				else if (s_axi_araddr == `REG_ROW)
					s_axi_rdata <= {16'h0, row_ff[row_sel_ff]};
				else if (s_axi_araddr == `REG_LAT)
					s_axi_rdata <= {27'h0, lat_ff};
				else
				begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= `RESP_ERR;
				end
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- ddr3_cmd_map.svh ----
// Address, command and timing constants of the DDR3 command block
`ifndef DDR3_CMD_MAP_SVH
`define DDR3_CMD_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (AXI4-Lite byte addresses)
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_MODE 8'h04
`define REG_BANK_OPEN 8'h08
`define REG_BANK_PRE 8'h0c
`define REG_ROW_SEL 8'h10
`define REG_ROW 8'h14
`define REG_LAT 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_DLL_LOCK 0
`define CTRL_REPL 1
`define MODE_MPR_EN 2
`define MODE_OTF 3
`define MR3_MPR_EN_BIT 2
`define A_AP 10
`define A_BC 12

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define CTRL_RST 2'h1
`define LAT_RST 5'h05
`define MPR_LOC_PATTERN 2'h0
`define MPR_PATTERN 8'haa
`define TRP_NS 14
`define CLK_NS 25
`define TRP_CYC ((`TRP_NS + `CLK_NS - 1) / `CLK_NS)
`define BEAT_LAST 3'h7
`define BEAT_CHOP_LAST 2'h3
`define RESP_OK 2'h0
`define RESP_ERR 2'h2

`endif

// ---- ddr3_cmd_pkg.sv ----
// Types of the DDR3 command block
`default_nettype none
package ddr3_cmd_pkg;
	typedef enum logic [2:0]
	{
		cmd_nop,
		cmd_act,
		cmd_pre,
		cmd_rd,
		cmd_wr,
		cmd_mrs
	} cmd_t;
	typedef enum logic [1:0]
	{
		bank_idle,
		bank_open,
		bank_precharging
	} bank_state_t;
	typedef enum
	{
		rd_wait,
		rd_burst
	} rd_state_t;
endpackage
`default_nettype wire

// ---- mpr_beat_gen.sv ----
// Beat selection and lane fan-out for multi purpose register reads
`timescale 1ns/10ps
`default_nettype none
`include "ddr3_cmd_map.svh"

module mpr_beat_gen
(
	input wire logic [7:0] pattern,
	input wire logic [2:0] beat,
	input wire logic replicate,
	output logic [7:0] dq
);
	logic bit_val;

	// Beat n reads bit n: beat 0 is the LSB
	assign bit_val = pattern[beat];

	// Lane 0 carries the bit; upper lanes copy it or stay low
	assign dq[0] = bit_val;
	genvar g;
	generate
		for (g = 1; g < 8; g = g + 1)
		begin : lanes
			assign dq[g] = replicate ? bit_val : 1'b0;
		end
	endgenerate
endmodule
`default_nettype wire

// ---- ddr3_mpr_bank_sva.sv ----
// Assertion checker for the DDR3 MPR and bank command block
`timescale 1ns/10ps
`default_nettype none
module ddr3_mpr_bank_sva
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire ddr3_cmd_pkg::cmd_t cmd,
	input wire logic [7:0] dq_out,
	input wire logic dq_oe,
	input wire logic array_rd,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_rvalid
);
	import ddr3_cmd_pkg::*;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence seq_chop;
		dq_oe[*4];
	endsequence
	sequence seq_full;
		seq_chop ##1 seq_chop;
	endsequence
	a_lane_copy: assert property (dq_oe |-> (dq_out[7:1] == {7{dq_out[0]}} || dq_out[7:1] == 7'h00))
		else $error("lanes 7..1 neither copy lane 0 nor read zero");
	a_first_beat: assert property ($rose(dq_oe) |-> dq_out[0] == 1'b0)
		else $error("first beat of a burst is not 0");
	a_beat_toggle: assert property (dq_oe && $past(dq_oe) |-> dq_out[0] != $past(dq_out[0]))
		else $error("pattern does not alternate");
	a_burst_len: assert property ($rose(dq_oe) |-> (seq_chop ##1 !dq_oe) or (seq_full ##1 !dq_oe))
		else $error("burst is neither 4 nor 8 beats");
	a_read_answer: assert property (cmd == cmd_rd |-> ##[1:40] (array_rd || dq_oe))
		else $error("read produced neither array read nor MPR burst");
	a_array_pulse: assert property (array_rd |=> !array_rd)
		else $error("array read pulse longer than one cycle");
	a_write_answer: assert property ($rose(s_axi_awvalid) |-> ##[1:8] s_axi_bvalid)
		else $error("write response late");
	a_read_resp: assert property ($rose(s_axi_arvalid) |-> ##[1:8] s_axi_rvalid)
		else $error("read response late");
endmodule
bind ddr3_mpr_bank ddr3_mpr_bank_sva ddr3_mpr_bank_sva_i
(
	.aclk(aclk), .aresetn(aresetn), .cmd(cmd), .dq_out(dq_out), .dq_oe(dq_oe),
	.array_rd(array_rd), .s_axi_awvalid(s_axi_awvalid), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid)
);
`default_nettype wire

// ---- ddr3_ctrl_model.sv ----
// Memory controller model issuing commands on the command bus
`timescale 1ns/10ps
`default_nettype none
module ddr3_ctrl_model
(
	input wire logic aclk,
	output var ddr3_cmd_pkg::cmd_t cmd,
	output var logic [2:0] cmd_ba,
	output var logic [15:0] cmd_addr
);
	import ddr3_cmd_pkg::*;
	initial
	begin
		cmd = cmd_nop;
		cmd_ba = 3'h0;
		cmd_addr = 16'h0000;
	end
	task automatic issue(input cmd_t op, input logic [2:0] ba, input logic [15:0] a);
		@(posedge aclk);
		cmd <= op;
		cmd_ba <= ba;
		cmd_addr <= (op == cmd_rd) ? {a[15:3], a[2] & ~a[12], 2'b00} : a;
		@(posedge aclk);
		cmd <= cmd_nop;
		cmd_ba <= ~ba;
		cmd_addr <= ~a;
		if (op == cmd_pre)
			@(posedge aclk);
	endtask
endmodule
`default_nettype wire

// ---- ddr3_mpr_bank_tb.sv ----
// Self-checking bench of the DDR3 MPR and bank command block
`timescale 1ns/10ps
`default_nettype none
module ddr3_mpr_bank_tb;
	import ddr3_cmd_pkg::*;
	logic aclk, aresetn, dq_oe, array_rd;
	cmd_t cmd;
	logic [2:0] cmd_ba;
	logic [15:0] cmd_addr;
	logic [7:0] dq_out, s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int err_count = 0;
	int n_compared = 0;
	int cyc = 0;
	int d5, d9;
	ddr3_ctrl_model ddr3_ctrl_model_i
	(
		.aclk(aclk), .cmd(cmd), .cmd_ba(cmd_ba), .cmd_addr(cmd_addr)
	);
	ddr3_mpr_bank ddr3_mpr_bank_i
	(
		.aclk(aclk), .aresetn(aresetn), .cmd(cmd), .cmd_ba(cmd_ba), .cmd_addr(cmd_addr),
		.dq_out(dq_out), .dq_oe(dq_oe), .array_rd(array_rd),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready)
	);
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic mpr(input logic [2:0] ba, input logic [15:0] a, input int nb, input int b0,
		input logic rep, output int dly);
		logic [7:0] pat = 8'haa;
		ddr3_ctrl_model_i.issue(cmd_rd, ba, a);
		dly = 0;
		do
		begin
			@(posedge aclk);
			dly++;
		end
		while (!dq_oe && dly < 60);
		for (int i = 0; i < nb; i++)
		begin
			chk("dq", rep ? {8{pat[b0 + i]}} : {7'h00, pat[b0 + i]}, dq_out);
			@(posedge aclk);
		end
		chk("oe", 1'b0, dq_oe);
	endtask
	task t_regs;
		rdr(8'h00);
		chk("ctrl", 32'h1, rd);
		rdr(8'h18);
		chk("lat", 32'h5, rd);
		rdr(8'h04);
		chk("mode", 32'h8, rd);
		rdr(8'h40);
		chk("unmapped", 32'h2, rs);
		wr(8'h08, 32'hff);
		chk("ro write", 32'h2, rs);
		$display("t_regs done");
	endtask
	task t_mpr;
		ddr3_ctrl_model_i.issue(cmd_mrs, 3'h3, 16'h0004);
		mpr(3'h7, 16'hfff8, 8, 0, 1'b0, d5);
		chk("latency", 32'd8, d5);
		mpr(3'h5, 16'hebf8, 4, 0, 1'b0, d9);
		mpr(3'h2, 16'hebfc, 4, 4, 1'b0, d9);
		wr(8'h18, 32'h9);
		mpr(3'h0, 16'h1000, 8, 0, 1'b0, d9);
		chk("latency", d5 + 4, d9);
		wr(8'h18, 32'h5);
		wr(8'h00, 32'h3);
		mpr(3'h1, 16'h1000, 8, 0, 1'b1, d9);
		wr(8'h00, 32'h1);
		$display("t_mpr done");
	endtask
	task t_chop;
		ddr3_ctrl_model_i.issue(cmd_mrs, 3'h0, 16'h0000);
		mpr(3'h0, 16'h0000, 8, 0, 1'b0, d9);
		wr(8'h04, 32'h4);
		rdr(8'h04);
		chk("mode", 32'h4, rd);
		mpr(3'h4, 16'h2800, 8, 0, 1'b0, d9);
		ddr3_ctrl_model_i.issue(cmd_mrs, 3'h0, 16'h0001);
		ddr3_ctrl_model_i.issue(cmd_mrs, 3'h3, 16'h0005);
		mpr(3'h0, 16'h1000, 8, 0, 1'b0, d9);
		$display("t_chop done");
	endtask
	task t_array;
		logic seen;
		logic oe;
		seen = 1'b0;
		oe = 1'b0;
		ddr3_ctrl_model_i.issue(cmd_mrs, 3'h3, 16'h0000);
		ddr3_ctrl_model_i.issue(cmd_rd, 3'h0, 16'h1000);
		repeat (40)
		begin
			@(posedge aclk);
			seen |= array_rd;
			oe |= dq_oe;
		end
		chk("array_rd", 1'b1, seen);
		chk("oe", 1'b0, oe);
		$display("t_array done");
	endtask
	task t_bank;
		ddr3_ctrl_model_i.issue(cmd_act, 3'h2, 16'hbeef);
		ddr3_ctrl_model_i.issue(cmd_act, 3'h5, 16'h0001);
		wr(8'h10, 32'h2);
		rdr(8'h14);
		chk("row", 32'hbeef, rd);
		rdr(8'h08);
		chk("open", 32'h24, rd);
		ddr3_ctrl_model_i.issue(cmd_pre, 3'h2, 16'h0000);
		ddr3_ctrl_model_i.issue(cmd_pre, 3'h2, 16'h0000);
		rdr(8'h08);
		chk("open", 32'h20, rd);
		rdr(8'h0c);
		chk("precharging", 32'h0, rd);
		ddr3_ctrl_model_i.issue(cmd_pre, 3'h0, 16'h0400);
		rdr(8'h08);
		chk("open", 32'h0, rd);
		ddr3_ctrl_model_i.issue(cmd_act, 3'h2, 16'h1234);
		rdr(8'h14);
		chk("row", 32'h1234, rd);
		$display("t_bank done");
	endtask
	task final_report;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		aclk = 1'b0;
		forever
			#12.5 aclk = ~aclk;
	end
	initial
	begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		repeat (8)
			@(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_mpr;
		t_chop;
		t_array;
		t_bank;
		final_report;
	end
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_count++;
			final_report;
		end
	end
endmodule
`default_nettype wire
